// *** inc/tla_pkg.sv ***
package tla_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL_OFS     = 8'h00;
   localparam logic [7:0] REG_ENABLE_OFS   = 8'h04;
   localparam logic [7:0] REG_FLAGS_OFS    = 8'h08;
   localparam logic [7:0] REG_OUTV_LIM_OFS = 8'h0c;
   localparam logic [7:0] REG_IBAT_LIM_OFS = 8'h10;
   localparam logic [7:0] REG_IIN_LIM_OFS  = 8'h14;
   localparam logic [7:0] REG_RES_LIM_OFS  = 8'h18;
   localparam logic [7:0] REG_TEMP_LIM_OFS = 8'h1c;
   localparam logic [7:0] REG_NTC_LIM_OFS  = 8'h20;
   localparam logic [7:0] REG_OPEN_NTC_OFS = 8'h24;
   localparam logic [7:0] REG_CHG_TGT_OFS  = 8'h28;
   localparam logic [7:0] REG_OUTV_OFS     = 8'h2c;
   localparam logic [7:0] REG_IBAT_OFS     = 8'h30;
   localparam logic [7:0] REG_IIN_OFS      = 8'h34;
   localparam logic [7:0] REG_TEMP_OFS     = 8'h38;
   localparam logic [7:0] REG_NTC_OFS      = 8'h3c;
   localparam logic [7:0] REG_RES_OFS      = 8'h40;
   localparam logic [7:0] REG_STATUS_OFS   = 8'h44;
   // Flag / enable bit positions
   localparam int F_OUTV_LO = 0;
   localparam int F_OUTV_HI = 1;
   localparam int F_IBAT_LO = 2;
   localparam int F_IIN_HI  = 3;
   localparam int F_RES_HI  = 4;
   localparam int F_TEMP_HI = 5;
   localparam int F_NTC_LO  = 6;
   localparam int F_NTC_HI  = 7;
   localparam int F_RES_DONE = 8;
   localparam int NFLAGS    = 9;
   // Control / status bits
   localparam int CTRL_RUN_RES  = 0;
   localparam int ST_QUESTION   = 0;
   localparam int ST_MISSING    = 1;
   localparam int ST_SUSPEND    = 2;
   // Reset values
   localparam logic [15:0] LIM_RST      = 16'h0000;
   localparam logic [15:0] OPEN_NTC_RST = 16'h7fff;
   localparam logic [15:0] CHG_TGT_RST  = 16'h0000;
   // Scaling figures and settle count; RES_SCALE and SETTLE_CYCLES feed the logic
   localparam real OUTV_LSB_MV   = 1.653;
   localparam real OUTV_ATTEN    = 30.07;
   localparam real TEMP_LSB_C    = 0.0215;
   localparam real TEMP_OFFS_C   = 264.4;
   localparam int  NTC_SPAN      = 18191;
   localparam real NTC_EXCITE_V  = 1.2;
   localparam int  RES_SCALE     = 500;
   localparam int  SETTLE_CYCLES = 16;

   typedef enum logic [4:0] {
      RS_IDLE   = 5'b00001,
      RS_WAIT   = 5'b00010,
      RS_SUSP   = 5'b00100,
      RS_DIV    = 5'b01000,
      RS_DONE   = 5'b10000
   } tla_rs_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } tla_sample_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  resp;
      logic [1:0]  rresp;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
   } tla_bus_t;

   typedef struct packed {
      tla_bus_t         bus;
      logic             run_res;
      logic [NFLAGS-1:0] en;
      logic [NFLAGS-1:0] flags;
      logic [15:0]      outv_lo, outv_hi, ibat_lo, iin_hi, res_hi, temp_hi;
      logic [15:0]      ntc_lo, ntc_hi, open_ntc, chg_tgt;
      logic [15:0]      outv, ibat, iin, temp, ntc, res, res_cur;
      logic             question, missing, suspend;
      tla_rs_t          rs;
      logic [15:0]      v_chg;
      logic [4:0]       settle;
      logic [31:0]      num;
      logic [15:0]      quo;
      logic [4:0]       bit_i;
      logic             alert_n;
   } tla_state_t;
endpackage

// *** logic/tla_core.sv ***
`timescale 1ns/1ps
// Behaviour
// - Output voltage code stored as given, 1.653 mV per LSB after 30.07:1 divider.
// - Enabled output-voltage low/high flags set below low or above high limit.
// - Alert flags stay set until software writes zero to them.
// - Battery current is signed, positive charging, negative when suspended.
// - Enabled battery current low flag uses signed compare, negative limits allowed.
// - Enabled input-current high flag sets when code exceeds upper limit.
// - Resistance request suspends charging, divides voltage delta by charge current.
// - Resistance result and measured charge current reported in separate fields.
// - Request bit clears itself when the measurement finishes.
// - Questionable bit set when measured current below one tenth of target.
// - Request without a running charge cycle waits for next cycle start.
// - Enabled measurement-done flag sets when a result is available.
// - Enabled resistance high flag per cell; software scales pack limit by cells.
// - Die temperature code maps as code times 0.0215 minus 264.4 degrees.
// - Enabled die temperature high flag sets when code exceeds limit.
// - Thermistor code above open threshold while detecting or charging forces missing fault.
// - Enabled thermistor low and high flags compare code with limits.
// - Thermistor code equals 18191 times 1.2 times divider ratio.
// - Results and limits are 16-bit signed, compared signed.
// - Active-low shared alert driven while any enabled flag is set.
module tla_core
   import tla_pkg::*;
#(
   parameter int W = 16
)(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // AXI4-Lite slave
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Converter results, one-cycle valid
   input  wire tla_sample_t OUTV_IN,
   input  wire tla_sample_t IBAT_IN,
   input  wire tla_sample_t IIN_IN,
   input  wire tla_sample_t TEMP_IN,
   input  wire tla_sample_t NTC_IN,
   input  wire tla_sample_t VBAT_IN,
   // Charger state
   input  wire logic        CHARGING,
   input  wire logic        BATT_DETECT,
   // Outputs
   output logic             SUSPEND_REQ,
   output logic             BATT_MISSING,
   output logic             SHARED_ALERT_OUT_N
);
   tla_state_t s_r, s_nxt;

   function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
      logic [15:0] r;
      r = old;
      if (st[0]) r[7:0] = d[7:0];
      if (st[1]) r[15:8] = d[15:8];
      return r;
   endfunction

   function automatic logic lt_s(input logic [15:0] a, input logic [15:0] b);
      return $signed(a) < $signed(b);
   endfunction

   logic [NFLAGS-1:0] hit;
   logic [31:0]       rd;
   logic              rd_ok, wr_ok;
   logic [16:0]       dv;
   logic [15:0]       tenth;

   always_comb
   begin
      s_nxt = s_r;
      hit   = '0;
      rd    = '0;
      rd_ok = 1'b1;
      wr_ok = 1'b1;
      dv    = '0;
      tenth = 16'($signed(s_r.chg_tgt) / 10);

      // Fresh results latched, checks run on the same strobe
      if (OUTV_IN.valid)
      begin
         s_nxt.outv = OUTV_IN.data;
         hit[F_OUTV_LO] = lt_s(OUTV_IN.data, s_r.outv_lo);
         hit[F_OUTV_HI] = lt_s(s_r.outv_hi, OUTV_IN.data);
      end
      if (IBAT_IN.valid)
      begin
         s_nxt.ibat = IBAT_IN.data;
         hit[F_IBAT_LO] = lt_s(IBAT_IN.data, s_r.ibat_lo);
      end
      if (IIN_IN.valid)
      begin
         s_nxt.iin = IIN_IN.data;
         hit[F_IIN_HI] = lt_s(s_r.iin_hi, IIN_IN.data);
      end
      if (TEMP_IN.valid)
      begin
         s_nxt.temp = TEMP_IN.data;
         hit[F_TEMP_HI] = lt_s(s_r.temp_hi, TEMP_IN.data);
      end
      if (NTC_IN.valid)
      begin
         s_nxt.ntc = NTC_IN.data;
         hit[F_NTC_LO] = lt_s(NTC_IN.data, s_r.ntc_lo);
         hit[F_NTC_HI] = lt_s(s_r.ntc_hi, NTC_IN.data);
         if ((BATT_DETECT || CHARGING) && lt_s(s_r.open_ntc, NTC_IN.data))
            s_nxt.missing = 1'b1;
      end
      if (!BATT_DETECT && !CHARGING && s_r.missing && NTC_IN.valid
          && !lt_s(s_r.open_ntc, NTC_IN.data))
         s_nxt.missing = 1'b0;

      // Resistance measurement sequence
      case (s_r.rs)
         RS_IDLE:
         begin
            if (s_r.run_res)
               s_nxt.rs = RS_WAIT;
         end
         RS_WAIT:
         begin
            // Queued until a charge cycle is under way
            if (CHARGING && s_r.missing == 1'b0 && VBAT_IN.valid && IBAT_IN.valid)
            begin
               s_nxt.v_chg   = VBAT_IN.data;
               s_nxt.res_cur = IBAT_IN.data;
               s_nxt.suspend = 1'b1;
               s_nxt.settle  = 5'(SETTLE_CYCLES);
               s_nxt.rs      = RS_SUSP;
            end
         end
         RS_SUSP:
         begin
            if (s_r.settle != 5'h00)
               s_nxt.settle = s_r.settle - 5'h01;
            else if (VBAT_IN.valid)
            begin
               s_nxt.suspend = 1'b0;
               s_nxt.num   = 32'($signed(s_r.v_chg) - $signed(VBAT_IN.data)) * RES_SCALE;
               if ($signed(s_nxt.num) < 0)
                  s_nxt.num = '0;
               s_nxt.quo   = '0;
               s_nxt.bit_i = 5'h0f;
               s_nxt.rs    = RS_DIV;
            end
         end
         RS_DIV:
         begin
            // Restoring division, one quotient bit a cycle; saves a wide divider
            // Trial subtract on num[31:15] first, then the next dividend bit is shifted in
            dv = s_r.num[31:15] - {1'b0, s_r.res_cur};
            s_nxt.num = {s_r.num[30:0], 1'b0};
            if (s_r.res_cur != 16'h0000 && !dv[16] && !s_r.res_cur[15])
            begin
               s_nxt.num = {dv[15:0], s_r.num[14:0], 1'b0};
               s_nxt.quo[s_r.bit_i[3:0]] = 1'b1;
            end
            if (s_r.bit_i == 5'h00)
               s_nxt.rs = RS_DONE;
            else
               s_nxt.bit_i = s_r.bit_i - 5'h01;
         end
         RS_DONE:
         begin
            s_nxt.res      = s_r.quo;
            s_nxt.question = lt_s(s_r.res_cur, tenth);
            s_nxt.run_res  = 1'b0;
            hit[F_RES_DONE] = 1'b1;
            hit[F_RES_HI]   = lt_s(s_r.res_hi, s_r.quo);
            s_nxt.rs       = RS_IDLE;
         end
         default: s_nxt.rs = RS_IDLE;
      endcase

      // AXI4-Lite write path
      if (S_AXI_AWVALID && s_r.bus.awready)
      begin
         s_nxt.bus.aw_got  = 1'b1;
         s_nxt.bus.awaddr  = S_AXI_AWADDR;
         s_nxt.bus.awready = 1'b0;
      end
      if (S_AXI_WVALID && s_r.bus.wready)
      begin
         s_nxt.bus.w_got  = 1'b1;
         s_nxt.bus.wdata  = S_AXI_WDATA;
         s_nxt.bus.wstrb  = S_AXI_WSTRB;
         s_nxt.bus.wready = 1'b0;
      end
      if (s_r.bus.aw_got && s_r.bus.w_got && !s_r.bus.bvalid)
      begin
         case (s_r.bus.awaddr)
            REG_CTRL_OFS:
               if (s_r.bus.wstrb[0] && s_r.bus.wdata[CTRL_RUN_RES])
                  s_nxt.run_res = 1'b1;
            REG_ENABLE_OFS:
               s_nxt.en = NFLAGS'(wmerge(16'(s_r.en), s_r.bus.wdata, s_r.bus.wstrb));
            REG_FLAGS_OFS:
            begin
               // Writing zero clears; a same-cycle hit below still wins
               for (int i = 0; i < NFLAGS; i++)
                  if (s_r.bus.wstrb[i/8] && !s_r.bus.wdata[i])
                     s_nxt.flags[i] = 1'b0;
            end
            REG_OUTV_LIM_OFS:
            begin
               s_nxt.outv_lo = wmerge(s_r.outv_lo, s_r.bus.wdata, s_r.bus.wstrb);
               s_nxt.outv_hi = wmerge(s_r.outv_hi, s_r.bus.wdata >> 16,
                                      s_r.bus.wstrb >> 2);
            end
            REG_IBAT_LIM_OFS: s_nxt.ibat_lo = wmerge(s_r.ibat_lo, s_r.bus.wdata, s_r.bus.wstrb);
            REG_IIN_LIM_OFS:  s_nxt.iin_hi  = wmerge(s_r.iin_hi, s_r.bus.wdata, s_r.bus.wstrb);
            REG_RES_LIM_OFS:  s_nxt.res_hi  = wmerge(s_r.res_hi, s_r.bus.wdata, s_r.bus.wstrb);
            REG_TEMP_LIM_OFS: s_nxt.temp_hi = wmerge(s_r.temp_hi, s_r.bus.wdata, s_r.bus.wstrb);
            REG_NTC_LIM_OFS:
            begin
               s_nxt.ntc_lo = wmerge(s_r.ntc_lo, s_r.bus.wdata, s_r.bus.wstrb);
               s_nxt.ntc_hi = wmerge(s_r.ntc_hi, s_r.bus.wdata >> 16, s_r.bus.wstrb >> 2);
            end
            REG_OPEN_NTC_OFS: s_nxt.open_ntc = wmerge(s_r.open_ntc, s_r.bus.wdata,
                                                      s_r.bus.wstrb);
            REG_CHG_TGT_OFS:  s_nxt.chg_tgt = wmerge(s_r.chg_tgt, s_r.bus.wdata, s_r.bus.wstrb);
            default: wr_ok = 1'b0;
         endcase
         s_nxt.bus.bvalid = 1'b1;
         s_nxt.bus.resp   = wr_ok ? 2'h0 : 2'h2;
      end
      if (s_r.bus.bvalid && S_AXI_BREADY)
      begin
         s_nxt.bus.bvalid  = 1'b0;
         s_nxt.bus.aw_got  = 1'b0;
         s_nxt.bus.w_got   = 1'b0;
         s_nxt.bus.awready = 1'b1;
         s_nxt.bus.wready  = 1'b1;
      end

      // Hardware set beats software clear
      for (int i = 0; i < NFLAGS; i++)
         if (hit[i] && s_r.en[i])
            s_nxt.flags[i] = 1'b1;

      // AXI4-Lite read path
      case (S_AXI_ARADDR)
         REG_CTRL_OFS:     rd = {31'h0, s_r.run_res};
         REG_ENABLE_OFS:   rd = 32'(s_r.en);
         REG_FLAGS_OFS:    rd = 32'(s_r.flags);
         REG_OUTV_LIM_OFS: rd = {s_r.outv_hi, s_r.outv_lo};
         REG_IBAT_LIM_OFS: rd = {16'h0, s_r.ibat_lo};
         REG_IIN_LIM_OFS:  rd = {16'h0, s_r.iin_hi};
         REG_RES_LIM_OFS:  rd = {16'h0, s_r.res_hi};
         REG_TEMP_LIM_OFS: rd = {16'h0, s_r.temp_hi};
         REG_NTC_LIM_OFS:  rd = {s_r.ntc_hi, s_r.ntc_lo};
         REG_OPEN_NTC_OFS: rd = {16'h0, s_r.open_ntc};
         REG_CHG_TGT_OFS:  rd = {16'h0, s_r.chg_tgt};
         REG_OUTV_OFS:     rd = {16'h0, s_r.outv};
         REG_IBAT_OFS:     rd = {16'h0, s_r.ibat};
         REG_IIN_OFS:      rd = {16'h0, s_r.iin};
         REG_TEMP_OFS:     rd = {16'h0, s_r.temp};
         REG_NTC_OFS:      rd = {16'h0, s_r.ntc};
         REG_RES_OFS:      rd = {s_r.res_cur, s_r.res};
         REG_STATUS_OFS:   rd = {29'h0, s_r.suspend, s_r.missing, s_r.question};
         default:          rd_ok = 1'b0;
      endcase
      if (S_AXI_ARVALID && s_r.bus.arready)
      begin
         s_nxt.bus.arready = 1'b0;
         s_nxt.bus.rvalid  = 1'b1;
         s_nxt.bus.rdata   = rd;
         s_nxt.bus.rresp   = rd_ok ? 2'h0 : 2'h2;
      end
      if (s_r.bus.rvalid && S_AXI_RREADY)
      begin
         s_nxt.bus.rvalid  = 1'b0;
         s_nxt.bus.arready = 1'b1;
      end

      s_nxt.alert_n = ~|(s_nxt.flags & s_nxt.en);
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         s_r          <= '0;
         s_r.bus.awready <= 1'b1;
         s_r.bus.wready  <= 1'b1;
         s_r.bus.arready <= 1'b1;
         s_r.outv_lo  <= LIM_RST;
         s_r.outv_hi  <= LIM_RST;
         s_r.open_ntc <= OPEN_NTC_RST;
         s_r.chg_tgt  <= CHG_TGT_RST;
         s_r.rs       <= RS_IDLE;
         s_r.alert_n  <= 1'b1;
      end
      else
         s_r <= s_nxt;
   end

   assign S_AXI_AWREADY      = s_r.bus.awready;
   assign S_AXI_WREADY       = s_r.bus.wready;
   assign S_AXI_BVALID       = s_r.bus.bvalid;
   assign S_AXI_BRESP        = s_r.bus.resp;
   assign S_AXI_ARREADY      = s_r.bus.arready;
   assign S_AXI_RVALID       = s_r.bus.rvalid;
   assign S_AXI_RDATA        = s_r.bus.rdata;
   assign S_AXI_RRESP        = s_r.bus.rresp;
   assign SUSPEND_REQ        = s_r.suspend;
   assign BATT_MISSING       = s_r.missing;
   assign SHARED_ALERT_OUT_N = s_r.alert_n;
endmodule // tla_core

// *** dv/tla_host.sv ***
`timescale 1ns/1ps
module tla_host
(
   // Clock
   input  wire logic        clk,
   // Write side
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   // Read side
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial
   begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // Response ready held up front; each channel drops valid only on its own handshake
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= 4'hf;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!done)
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!done)
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
endmodule // tla_host

// *** dv/tla_core_asserts.sv ***
`timescale 1ns/1ps
module tla_core_asserts
   import tla_pkg::*;
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST,
   // Bus handshakes
   input  wire logic        S_AXI_AWVALID,
   input  wire logic        S_AXI_AWREADY,
   input  wire logic        S_AXI_WVALID,
   input  wire logic        S_AXI_WREADY,
   input  wire logic [1:0]  S_AXI_BRESP,
   input  wire logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic        S_AXI_ARVALID,
   input  wire logic        S_AXI_ARREADY,
   input  wire logic [31:0] S_AXI_RDATA,
   input  wire logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Charger side
   input  wire tla_sample_t NTC_IN,
   input  wire logic        CHARGING,
   input  wire logic        BATT_DETECT,
   input  wire logic        SUSPEND_REQ,
   input  wire logic        BATT_MISSING,
   input  wire logic        SHARED_ALERT_OUT_N
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_susp_hold;
      SUSPEND_REQ [*8];
   endsequence
   property p_rst;
      disable iff (1'b0) RST |=> !S_AXI_BVALID && !S_AXI_RVALID && SHARED_ALERT_OUT_N
         && !SUSPEND_REQ;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   property p_b_hold;
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_lat;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   property p_b_lat;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
   endproperty
   a_b_lat: assert property (p_b_lat) else $error("write answer late");
   property p_ready_lo;
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY;
   endproperty
   a_ready_lo: assert property (p_ready_lo) else $error("ready during response");
   property p_susp;
      $rose(SUSPEND_REQ) |-> s_susp_hold;
   endproperty
   a_susp: assert property (p_susp) else $error("suspend too short");
   property p_susp_cause;
      $rose(SUSPEND_REQ) |-> $past(CHARGING);
   endproperty
   a_susp_cause: assert property (p_susp_cause) else $error("suspend while idle");
   property p_miss;
      $rose(BATT_MISSING) |-> $past(NTC_IN.valid) && ($past(CHARGING) || $past(BATT_DETECT));
   endproperty
   a_miss: assert property (p_miss) else $error("missing fault without cause");
endmodule // tla_core_asserts

bind tla_core tla_core_asserts i_chk (.CLK(CLK), .RST(RST),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY), .NTC_IN(NTC_IN), .CHARGING(CHARGING),
   .BATT_DETECT(BATT_DETECT), .SUSPEND_REQ(SUSPEND_REQ), .BATT_MISSING(BATT_MISSING),
   .SHARED_ALERT_OUT_N(SHARED_ALERT_OUT_N));

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
   import tla_pkg::*;
   logic        clk, rst, charging, batt_detect, susp, missing, alert_n;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   tla_sample_t smp [6];
   int          errors, cmp_count, cyc;
   tla_core i_dut (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .OUTV_IN(smp[0]), .IBAT_IN(smp[1]), .IIN_IN(smp[2]), .TEMP_IN(smp[3]), .NTC_IN(smp[4]),
      .VBAT_IN(smp[5]), .CHARGING(charging), .BATT_DETECT(batt_detect), .SUSPEND_REQ(susp),
      .BATT_MISSING(missing), .SHARED_ALERT_OUT_N(alert_n));
   tla_host i_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic print_verdict;
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard; whole run needs a few hundred cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         print_verdict();
      end
   end
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      i_host.wr(a, d, r);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] d;
      i_host.rd(a, d, r);
      chk(exp, d & m);
   endtask
   task automatic put(input int i, input logic [15:0] d);
      @(posedge clk);
      smp[i] <= '{1'b1, d};
      @(posedge clk);
      smp[i].valid <= 1'b0;
   endtask
   task automatic pair(input logic [15:0] v, input logic [15:0] c);
      @(posedge clk);
      smp[5] <= '{1'b1, v};
      smp[1] <= '{1'b1, c};
      @(posedge clk);
      smp[5].valid <= 1'b0;
      smp[1].valid <= 1'b0;
   endtask
   task automatic t_bus;
      rc(REG_OPEN_NTC_OFS, 32'h0000ffff, 32'h00007fff);
      rc(REG_FLAGS_OFS, 32'h000001ff, 32'h0);
      i_host.wr(8'h4c, 32'h1, r);
      chk(32'(r), 32'h2);
      rc(8'h48, 32'hffffffff, 32'h0);
      chk(32'(r), 32'h2);
   endtask
   task automatic t_outv;
      w(REG_ENABLE_OFS, 32'h3);
      w(REG_OUTV_LIM_OFS, 32'h03e8ff9c);
      put(0, 16'hff38);
      rc(REG_OUTV_OFS, 32'h0000ffff, 32'h0000ff38);
      put(0, 16'h07d0);
      put(0, 16'h0000);
      rc(REG_FLAGS_OFS, 32'h000001ff, 32'h3);
      chk(32'(alert_n), 32'h0);
      w(REG_FLAGS_OFS, 32'h2);
      rc(REG_FLAGS_OFS, 32'h000001ff, 32'h2);
      w(REG_FLAGS_OFS, 32'h0);
      chk(32'(alert_n), 32'h1);
   endtask
   task automatic t_curr;
      w(REG_ENABLE_OFS, 32'h4);
      w(REG_IBAT_LIM_OFS, 32'h0000ffce);
      put(1, 16'hffcf);
      rc(REG_FLAGS_OFS, 32'h000001ff, 32'h0);
      put(1, 16'hffcd);
      rc(REG_IBAT_OFS, 32'h0000ffff, 32'h0000ffcd);
      w(REG_IIN_LIM_OFS, 32'h64);
      put(2, 16'h7fff);
      rc(REG_FLAGS_OFS, 32'h000001ff, 32'h4);
      w(REG_ENABLE_OFS, 32'hc);
      put(2, 16'h0065);
      rc(REG_FLAGS_OFS, 32'h000001ff, 32'hc);
      w(REG_FLAGS_OFS, 32'h0);
   endtask
   task automatic t_temp;
      w(REG_ENABLE_OFS, 32'he0);
      w(REG_TEMP_LIM_OFS, 32'h3000);
      w(REG_NTC_LIM_OFS, 32'h20001000);
      put(3, 16'h3000);
      put(4, 16'h1000);
      rc(REG_FLAGS_OFS, 32'h000001ff, 32'h0);
      put(3, 16'h3001);
      rc(REG_TEMP_OFS, 32'h0000ffff, 32'h3001);
      put(4, 16'h0fff);
      put(4, 16'h2001);
      rc(REG_NTC_OFS, 32'h0000ffff, 32'h2001);
      rc(REG_FLAGS_OFS, 32'h000001ff, 32'he0);
      w(REG_ENABLE_OFS, 32'h0);
      w(REG_FLAGS_OFS, 32'h0);
      w(REG_OPEN_NTC_OFS, 32'h4000);
      put(4, 16'h5000);
      chk(32'(missing), 32'h0);
      batt_detect <= 1'b1;
      put(4, 16'h5000);
      rc(REG_STATUS_OFS, 32'h2, 32'h2);
      chk(32'(missing), 32'h1);
      batt_detect <= 1'b0;
      put(4, 16'h1000);
      rc(REG_STATUS_OFS, 32'h2, 32'h0);
      chk(32'(alert_n), 32'h1);
   endtask
   task automatic t_res;
      logic [31:0] d;
      w(REG_ENABLE_OFS, 32'h110);
      w(REG_RES_LIM_OFS, 32'(8 / 4)); // Pack limit scaled per cell
      w(REG_CHG_TGT_OFS, 32'd1000);
      w(REG_CTRL_OFS, 32'h1);
      pair(16'd2000, 16'd50);
      repeat (4) @(posedge clk);
      chk(32'(susp), 32'h0);
      rc(REG_CTRL_OFS, 32'h1, 32'h1);
      charging <= 1'b1;
      pair(16'd2000, 16'd50);
      for (int n = 0; n < 8 && susp !== 1'b1; n++) @(posedge clk);
      chk(32'(susp), 32'h1);
      repeat (20) @(posedge clk);
      pair(16'd1900, 16'hffce);
      d = 32'h1;
      for (int n = 0; n < 20 && d[0] !== 1'b0; n++) i_host.rd(REG_CTRL_OFS, d, r);
      chk(32'h0, d & 32'h1);
      chk(32'(susp), 32'h0);
      // (2000-1900)*500/50 per cell, with observed current alongside
      rc(REG_RES_OFS, 32'hffffffff, {16'd50, 16'd1000});
      rc(REG_STATUS_OFS, 32'h1, 32'h1);
      rc(REG_FLAGS_OFS, 32'h000001ff, 32'h110);
      chk(32'(alert_n), 32'h0);
      charging <= 1'b0;
   endtask
   initial
   begin
      rst = 1'b1;
      charging = 1'b0;
      batt_detect = 1'b0;
      smp = '{default: '0};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_bus();
      t_outv();
      t_curr();
      t_temp();
      t_res();
      print_verdict();
   end
endmodule // testbench
